// ==== dpab_pkg.sv ====
// Constants and types for the data port address bounds check stage.
// Assumes one 50 MHz clock and a synchronous active-high reset in the user.
// Functional notes
// - Each message gives one common base offset plus per-lane offsets.
// - Per-lane offsets are byte offsets or element indices scaled by data width.
// - Common base offset is added to each lane offset to form combined offset.
// - Every combined offset is checked against surface and message limits first; the 64-bit stateless model skips the surface limit.
// - In-bound lanes add the model base address and issue to the cache path.
// - Out-of-bound lanes suppress the access and take the message action.
// - 64-bit stateless addresses crossing canonical boundary report fault or out-of-bound.
// - Access to a null tile is treated as out of bounds.
// - Access to an invalid tile raises a page fault.
// - Tile mapping works on 64KB regions within the tiled range.
// - Access to a mapped tile proceeds like any ordinary virtual address.
// - Only linear buffer surfaces unless the message allows structured surfaces.
// - Out-of-bound or null-tile reads return zero; writes are dropped.
// - A failed canonical check makes every byte of that offset out of bounds; with msg_canon_fault_mode set the lane faults instead.
`default_nettype none
package dpab_pkg;
   localparam int unsigned ADDR_W = 64;
   localparam int unsigned TILE_SHIFT = 16;  // 64KB tile region
   localparam int unsigned VA_MSB_DEF = 47;  // Top bit of the virtual address
   localparam int unsigned LANES_DEF = 8;
   localparam int unsigned TILE_IDX_W_DEF = 4;

   // Address model of the message
   typedef enum logic [1:0] {
      AM_SURFACE_STATE = 2'h0,
      AM_STATELESS_A32 = 2'h1,
      AM_STATELESS_A64 = 2'h2,
      AM_SHARED_LOCAL_MEMORY = 2'h3
   } dpab_model_type;

   // Tile translation table entry state
   typedef enum logic [1:0] {
      TILE_NULL = 2'h0,
      TILE_INVALID = 2'h1,
      TILE_MAPPED = 2'h2
   } dpab_tile_type;

   // Surface type code for the linear buffer surface
   localparam logic [2:0] LINEAR_BUFFER_SURFACE = 3'h4;
   localparam logic [1:0] TILE_RESET_STATE = 2'h0;

   // Output stage state, one-hot
   typedef enum logic [1:0] {
      ST_EMPTY = 2'h1,
      ST_FULL = 2'h2
   } dpab_state_type;
endpackage
`default_nettype wire

// ==== dpab_bounds_check.sv ====
// Address generation and bounds check stage for data port messages.
// Assumes message inputs come from logic on clk and the cache path consumes
// one result per cycle under a valid/ready handshake.
// Limitation: the whole check is one cycle of 64-bit adds and compares, so a
// wide lane count may need a pipeline stage to close timing at 50 MHz.
`timescale 1ns/1ns
`default_nettype none
module dpab_bounds_check #(
   parameter int unsigned LANES = dpab_pkg::LANES_DEF,
   parameter int unsigned VA_MSB = dpab_pkg::VA_MSB_DEF,
   parameter int unsigned TILE_IDX_W = dpab_pkg::TILE_IDX_W_DEF
) (
   input wire logic clk,
   input wire logic srst,
   // Message request
   input wire logic msg_valid,
   output logic msg_ready,
   input wire dpab_pkg::dpab_model_type msg_model,
   input wire logic msg_index_mode,
   input wire logic [1:0] msg_elem_log2,
   input wire logic msg_is_write,
   input wire logic msg_allow_structured,
   input wire logic [2:0] msg_surface_type,
   input wire logic msg_canon_fault_mode,
   input wire logic [dpab_pkg::ADDR_W-1:0] msg_base_offset,
   input wire logic [dpab_pkg::ADDR_W-1:0] msg_model_base,
   input wire logic [dpab_pkg::ADDR_W-1:0] msg_surface_limit,
   input wire logic [dpab_pkg::ADDR_W-1:0] msg_message_limit,
   input wire logic [LANES-1:0] msg_lane_mask,
   input wire logic [LANES*dpab_pkg::ADDR_W-1:0] msg_lane_offset,
   // Tile translation table setup
   input wire logic tt_enable,
   input wire logic [dpab_pkg::ADDR_W-1:0] tt_range_base,
   input wire logic tile_wr_en,
   input wire logic [TILE_IDX_W-1:0] tile_wr_idx,
   input wire dpab_pkg::dpab_tile_type tile_wr_state,
   // Result toward the cache path
   output logic out_valid,
   input wire logic out_ready,
   output logic out_is_write,
   output logic out_bad_surface,
   output logic [LANES-1:0] out_issue,
   output logic [LANES-1:0] out_zero_fill,
   output logic [LANES-1:0] out_drop,
   output logic [LANES-1:0] out_fault,
   output logic [LANES*dpab_pkg::ADDR_W-1:0] out_addr
);
   // Local shorthands
   localparam int unsigned AW = dpab_pkg::ADDR_W;
   localparam int unsigned TILES = 2 ** TILE_IDX_W;

   // Tile translation table, one state code per 64KB region
   dpab_pkg::dpab_tile_type tile_q [TILES];
   dpab_pkg::dpab_tile_type tile_d [TILES];
   // Output slot control
   dpab_pkg::dpab_state_type state_q, state_d;
   logic take;
   // Combinational per-message and per-lane results
   logic bad_surface;
   logic [LANES-1:0] lane_issue, lane_zero, lane_drop, lane_fault;
   logic [LANES*AW-1:0] lane_addr;
   // Registered result, held until the cache path takes it
   logic is_write_q, is_write_d;
   logic bad_surface_q, bad_surface_d;
   logic [LANES-1:0] issue_q, issue_d;
   logic [LANES-1:0] zero_q, zero_d;
   logic [LANES-1:0] drop_q, drop_d;
   logic [LANES-1:0] fault_q, fault_d;
   logic [LANES*AW-1:0] addr_q, addr_d;

   // Accept a new message whenever the result slot is empty or being drained
   // (costs a combinational path from out_ready to msg_ready, saves a bubble)
   assign msg_ready = (state_q == dpab_pkg::ST_EMPTY) || out_ready;
   assign take = msg_valid && msg_ready;

   // Structured surfaces only for messages that declare support for them
   assign bad_surface = (msg_surface_type != dpab_pkg::LINEAR_BUFFER_SURFACE) && !msg_allow_structured;

   // Per-lane address and classification; lanes never look at each other
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      // Address path of this lane
      logic [AW-1:0] raw_off, scaled_off, comb_off, addr, tt_diff;
      // Classification of this lane
      logic in_bounds, canon_ok;
      logic in_tiled, tile_null, tile_invalid;
      logic active, oob, flt;
      dpab_pkg::dpab_tile_type tstate;

      assign raw_off = msg_lane_offset[i*AW +: AW];
      // Index mode scales by the element width; byte mode passes through
      assign scaled_off = msg_index_mode ? (raw_off << msg_elem_log2) : raw_off;
      assign comb_off = msg_base_offset + scaled_off;
      // Both limits are checked; the 64-bit stateless model has no surface size bound
      // Only the start byte is compared; natural alignment keeps the rest inside
      assign in_bounds = ((msg_model == dpab_pkg::AM_STATELESS_A64) || (comb_off < msg_surface_limit))
         && (comb_off < msg_message_limit);
      assign addr = msg_model_base + comb_off;
      // Upper bits must all copy the top virtual address bit
      // Other models rely on software keeping in-bound accesses canonical
      assign canon_ok = (msg_model != dpab_pkg::AM_STATELESS_A64)
         || (&addr[AW-1:VA_MSB]) || !(|addr[AW-1:VA_MSB]);
      // Tiled range lookup in 64KB regions; shared local memory is never tiled
      assign tt_diff = addr - tt_range_base;
      assign in_tiled = tt_enable && (msg_model != dpab_pkg::AM_SHARED_LOCAL_MEMORY) && (addr >= tt_range_base)
         && (tt_diff[AW-1:dpab_pkg::TILE_SHIFT+TILE_IDX_W] == '0);
      assign tstate = tile_q[tt_diff[dpab_pkg::TILE_SHIFT +: TILE_IDX_W]];
      // Mapped tiles fall through as ordinary addresses
      // Unused state code 3 counts as invalid, so it faults rather than leaks
      assign tile_null = in_tiled && (tstate == dpab_pkg::TILE_NULL);
      assign tile_invalid = in_tiled && (tstate != dpab_pkg::TILE_NULL) && (tstate != dpab_pkg::TILE_MAPPED);
      // Lanes outside the mask produce no outcome at all
      assign active = msg_lane_mask[i];
      // A non-canonical offset puts all its bytes out of bounds unless faulting
      assign oob = active && (!in_bounds || bad_surface || tile_null
         || (!canon_ok && !msg_canon_fault_mode));
      assign flt = active && !oob && ((!canon_ok && msg_canon_fault_mode) || tile_invalid);
      // Exactly one outcome per active lane
      assign lane_issue[i] = active && !oob && !flt;
      assign lane_zero[i] = oob && !msg_is_write;
      assign lane_drop[i] = oob && msg_is_write;
      assign lane_fault[i] = flt;
      // Suppressed lanes show a zero address so nothing stale leaks out
      assign lane_addr[i*AW +: AW] = lane_issue[i] ? addr : '0;
   end

   // Tile table next state: one write per cycle
   // A write counts for messages taken from the following edge on
   always_comb begin
      for (int t = 0; t < TILES; t++) begin
         tile_d[t] = tile_q[t];
      end
      if (tile_wr_en) begin
         tile_d[tile_wr_idx] = tile_wr_state;
      end
   end

   // Tile table register; all tiles start null so early accesses read as zero
   // Reset only through srst; there is no per-entry clear
   always_ff @(posedge clk) begin
      for (int t = 0; t < TILES; t++) begin
         if (srst) begin
            tile_q[t] <= dpab_pkg::dpab_tile_type'(dpab_pkg::TILE_RESET_STATE);
         end else begin
            tile_q[t] <= tile_d[t];
         end
      end
   end

   // Output slot next values; data only moves on an accepted message
   // Holding by default keeps a stalled result steady for the cache path
   always_comb begin
      state_d = state_q;
      is_write_d = is_write_q;
      bad_surface_d = bad_surface_q;
      issue_d = issue_q;
      zero_d = zero_q;
      drop_d = drop_q;
      fault_d = fault_q;
      addr_d = addr_q;
      // Slot empties only when drained with nothing new arriving
      case (state_q)
         dpab_pkg::ST_EMPTY: begin
            if (take) begin
               state_d = dpab_pkg::ST_FULL;
            end
         end
         dpab_pkg::ST_FULL: begin
            if (out_ready && !take) begin
               state_d = dpab_pkg::ST_EMPTY;
            end
         end
         default: begin
            state_d = dpab_pkg::ST_EMPTY;
         end
      endcase
      // Capture the outcome of an accepted message
      if (take) begin
         is_write_d = msg_is_write;
         bad_surface_d = bad_surface;
         issue_d = lane_issue;
         zero_d = lane_zero;
         drop_d = lane_drop;
         fault_d = lane_fault;
         addr_d = lane_addr;
      end
   end

   // Output slot registers
   // Synchronous reset empties the slot and clears every result field
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= dpab_pkg::ST_EMPTY;
         is_write_q <= 1'b0;
         bad_surface_q <= 1'b0;
         issue_q <= '0;
         zero_q <= '0;
         drop_q <= '0;
         fault_q <= '0;
         addr_q <= '0;
      end else begin
         state_q <= state_d;
         is_write_q <= is_write_d;
         bad_surface_q <= bad_surface_d;
         issue_q <= issue_d;
         zero_q <= zero_d;
         drop_q <= drop_d;
         fault_q <= fault_d;
         addr_q <= addr_d;
      end
   end

   // Outputs come straight from the slot registers
   assign out_valid = (state_q == dpab_pkg::ST_FULL);
   assign out_is_write = is_write_q;
   assign out_bad_surface = bad_surface_q;
   assign out_issue = issue_q;
   assign out_zero_fill = zero_q;
   assign out_drop = drop_q;
   assign out_fault = fault_q;
   assign out_addr = addr_q;
endmodule
`default_nettype wire

// ==== dpab_checker.sv ====
// Port assertions for the bounds check stage.
// Bound to every dpab_bounds_check instance.
`timescale 1ns/1ns
`default_nettype none
module dpab_checker #(parameter int unsigned LANES = 8) (
   input wire logic clk,
   input wire logic srst,
   input wire logic msg_valid,
   input wire logic msg_ready,
   input wire logic msg_is_write,
   input wire logic [LANES-1:0] msg_lane_mask,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic out_is_write,
   input wire logic out_bad_surface,
   input wire logic [LANES-1:0] out_issue,
   input wire logic [LANES-1:0] out_zero_fill,
   input wire logic [LANES-1:0] out_drop,
   input wire logic [LANES-1:0] out_fault,
   input wire logic [LANES*dpab_pkg::ADDR_W-1:0] out_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   chk_take_answer:
   assert property (msg_valid && msg_ready |=> out_valid) else $error("taken message gave no result");
   chk_result_holds:
   assert property (out_valid && !out_ready |=> out_valid && $stable(out_issue) && $stable(out_addr))
      else $error("result changed while stalled");
   chk_refuse_busy:
   assert property (out_valid && !out_ready |-> !msg_ready) else $error("message taken while stalled");
   chk_lane_exclusive:
   assert property (out_valid |-> (out_issue & (out_zero_fill | out_drop | out_fault)) == '0)
      else $error("lane has two outcomes");
   chk_inactive_quiet:
   assert property (msg_valid && msg_ready |=> ((out_issue | out_zero_fill | out_drop | out_fault)
      & ~$past(msg_lane_mask)) == '0) else $error("inactive lane acted");
   chk_read_zero:
   assert property (out_valid && !out_is_write |-> out_drop == '0) else $error("read lane dropped");
   chk_write_drop:
   assert property (out_valid && out_is_write |-> out_zero_fill == '0) else $error("write lane zero filled");
   chk_dir_follows:
   assert property (msg_valid && msg_ready |=> out_is_write == $past(msg_is_write)) else $error("direction lost");
   chk_bad_surface:
   assert property (out_valid && out_bad_surface |-> out_issue == '0) else $error("bad surface issued");
   chk_idle_addr:
   assert property (out_valid && !out_issue[0] |-> out_addr[63:0] == '0) else $error("address on idle lane");
endmodule
bind dpab_bounds_check dpab_checker #(.LANES(LANES)) dpab_checker_i (.clk(clk), .srst(srst),
   .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_is_write(msg_is_write), .msg_lane_mask(msg_lane_mask),
   .out_valid(out_valid), .out_ready(out_ready), .out_is_write(out_is_write), .out_bad_surface(out_bad_surface),
   .out_issue(out_issue), .out_zero_fill(out_zero_fill), .out_drop(out_drop), .out_fault(out_fault),
   .out_addr(out_addr));
`default_nettype wire

// ==== dpab_cache_model.sv ====
// Cache path stand-in that consumes results promptly or slowly.
// Assumes it shares clk and srst with the stage.
`timescale 1ns/1ns
`default_nettype none
module dpab_cache_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic slow,
   input wire logic out_valid,
   output logic out_ready,
   output logic [15:0] taken_q
);
   logic [1:0] cnt_q;
   // Slow mode accepts one cycle in four, so results must stand
   assign out_ready = !slow || (cnt_q == 2'h3);
   always_ff @(posedge clk) begin
      cnt_q <= srst ? 2'h0 : cnt_q + 2'h1;
      taken_q <= srst ? 16'h0 : taken_q + 16'(out_valid && out_ready);
   end
endmodule
`default_nettype wire

// ==== test_data_port_address_bounds_check.sv ====
// Self-checking bench for the bounds check stage.
// Assumes dpab_pkg, the stage, its checker and the cache model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_data_port_address_bounds_check;
   logic clk, srst, msg_valid, msg_ready, msg_index_mode, msg_is_write, msg_allow_structured;
   logic msg_canon_fault_mode, tt_enable, tile_wr_en, out_valid, out_ready, out_is_write, out_bad_surface, slow;
   dpab_pkg::dpab_model_type msg_model;
   dpab_pkg::dpab_tile_type tile_wr_state;
   logic [1:0] msg_elem_log2;
   logic [2:0] msg_surface_type;
   logic [3:0] tile_wr_idx;
   logic [7:0] msg_lane_mask, out_issue, out_zero_fill, out_drop, out_fault;
   logic [15:0] taken_q;
   logic [63:0] msg_base_offset, msg_model_base, msg_surface_limit, msg_message_limit, tt_range_base;
   logic [511:0] msg_lane_offset, out_addr;
   int err_count, checks_done;
   dpab_bounds_check dpab_bounds_check_i (.clk(clk), .srst(srst), .msg_valid(msg_valid), .msg_ready(msg_ready),
      .msg_model(msg_model), .msg_index_mode(msg_index_mode), .msg_elem_log2(msg_elem_log2),
      .msg_is_write(msg_is_write), .msg_allow_structured(msg_allow_structured), .msg_surface_type(msg_surface_type),
      .msg_canon_fault_mode(msg_canon_fault_mode), .msg_base_offset(msg_base_offset),
      .msg_model_base(msg_model_base), .msg_surface_limit(msg_surface_limit),
      .msg_message_limit(msg_message_limit), .msg_lane_mask(msg_lane_mask), .msg_lane_offset(msg_lane_offset),
      .tt_enable(tt_enable), .tt_range_base(tt_range_base), .tile_wr_en(tile_wr_en), .tile_wr_idx(tile_wr_idx),
      .tile_wr_state(tile_wr_state), .out_valid(out_valid), .out_ready(out_ready), .out_is_write(out_is_write),
      .out_bad_surface(out_bad_surface), .out_issue(out_issue), .out_zero_fill(out_zero_fill),
      .out_drop(out_drop), .out_fault(out_fault), .out_addr(out_addr));
   dpab_cache_model dpab_cache_model_i (.clk(clk), .srst(srst), .slow(slow), .out_valid(out_valid),
      .out_ready(out_ready), .taken_q(taken_q));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic res(input logic [7:0] i, input logic [7:0] z, input logic [7:0] d, input logic [7:0] f);
      chk(out_issue, i);
      chk(out_zero_fill, z);
      chk(out_drop, d);
      chk(out_fault, f);
   endtask
   task automatic setup(input dpab_pkg::dpab_model_type m, input logic w);
      msg_model = m;
      {msg_is_write, msg_index_mode, msg_elem_log2} = {w, 3'h0};
      {msg_allow_structured, msg_canon_fault_mode, tt_enable} = 3'h0;
      msg_surface_type = dpab_pkg::LINEAR_BUFFER_SURFACE;
      {msg_base_offset, msg_model_base, tt_range_base} = '0;
      {msg_surface_limit, msg_message_limit} = '1;
      msg_lane_mask = 8'hFF;
   endtask
   // Lane i offset is first + i * step; steps keep accesses aligned
   task automatic lanes(input logic [63:0] first, input logic [63:0] step);
      for (int i = 0; i < 8; i++) msg_lane_offset[i*64+:64] = first + 64'(i) * step;
   endtask
   // Offer one message at a falling edge and return once its result shows
   task automatic fire();
      int n;
      n = 0;
      // Let one edge pass so a previous request is never re-raised in the same step
      @(negedge clk);
      msg_valid = 1'b1;
      while (!msg_ready && n < 50) begin
         @(negedge clk);
         n++;
      end
      chk(msg_ready, 1'b1);
      @(negedge clk);
      msg_valid = 1'b0;
      chk(out_valid, 1'b1);
   endtask
   task automatic do_reset();
      srst = 1'b1;
      repeat (3) @(negedge clk);
      srst = 1'b0;
      chk({out_valid, msg_ready}, 2'h1);
   endtask
   task automatic sc_bounds();
      setup(dpab_pkg::AM_STATELESS_A32, 1'b0);
      {msg_base_offset, msg_model_base, msg_surface_limit} = {64'h100, 64'h1_0000, 64'h200};
      msg_lane_mask = 8'h7F;
      lanes(64'h0, 64'h40);
      fire();
      res(8'h0F, 8'h70, 8'h00, 8'h00);
      chk(out_addr[3*64+:64], 64'h1_01c0);
   endtask
   task automatic sc_index();
      for (int e = 0; e < 4; e++) begin
         setup(dpab_pkg::AM_SHARED_LOCAL_MEMORY, 1'b1);
         {msg_index_mode, msg_elem_log2, msg_model_base} = {1'b1, 2'(e), 64'h8000};
         msg_message_limit = 64'(4 << e);
         lanes(64'h0, 64'h1);
         fire();
         res(8'h0F, 8'h00, 8'hF0, 8'h00);
         chk(out_addr[2*64+:64], 64'h8000 + 64'(2 << e));
      end
   endtask
   task automatic sc_canon();
      for (int m = 0; m < 2; m++) begin
         setup(dpab_pkg::AM_STATELESS_A64, 1'b0);
         {msg_canon_fault_mode, msg_surface_limit, msg_model_base} = {1'(m), 64'h0, 64'h7fff_ffff_fff0};
         lanes(64'h0, 64'h8);
         fire();
         res(8'h03, m ? 8'h00 : 8'hFC, 8'h00, m ? 8'hFC : 8'h00);
      end
   endtask
   task automatic sc_tiles();
      for (int k = 0; k < 4; k++) begin
         {tile_wr_en, tile_wr_idx} = {1'b1, 4'(k)};
         tile_wr_state = dpab_pkg::dpab_tile_type'(2'(k));
         @(negedge clk);
      end
      tile_wr_en = 1'b0;
      setup(dpab_pkg::AM_STATELESS_A32, 1'b0);
      {tt_enable, tt_range_base, msg_model_base} = {1'b1, 64'h100_0000, 64'h100_0000};
      lanes(64'hfff0, 64'h1_0000);
      fire();
      res(8'h04, 8'hF1, 8'h00, 8'h0A);
      chk(out_addr[2*64+:64], 64'h102_fff0);
   endtask
   task automatic sc_surface();
      for (int a = 0; a < 2; a++) begin
         setup(dpab_pkg::AM_SURFACE_STATE, 1'b0);
         {msg_surface_type, msg_allow_structured} = {3'h1, 1'(a)};
         fire();
         chk(out_bad_surface, 1'(!a));
         res(a ? 8'hFF : 8'h00, a ? 8'h00 : 8'hFF, 8'h00, 8'h00);
      end
   endtask
   task automatic sc_stall();
      logic [15:0] t0;
      // Drain the previous result at full speed before slowing the consumer
      @(negedge clk);
      slow = 1'b1;
      setup(dpab_pkg::AM_STATELESS_A32, 1'b0);
      msg_lane_mask = 8'h0F;
      lanes(64'h0, 64'h4);
      t0 = taken_q;
      fire();
      res(8'h0F, 8'h00, 8'h00, 8'h00);
      chk(msg_ready, out_ready);
      {msg_is_write, msg_lane_mask, msg_message_limit} = {1'b1, 8'hFF, 64'h0};
      fire();
      chk(out_is_write, 1'b1);
      res(8'h00, 8'h00, 8'hFF, 8'h00);
      chk(16'(taken_q - t0), 16'h1);
      slow = 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      {srst, msg_valid, tile_wr_en, slow, tile_wr_idx, msg_lane_offset} = '0;
      tile_wr_state = dpab_pkg::TILE_NULL;
      setup(dpab_pkg::AM_STATELESS_A32, 1'b0);
      {err_count, checks_done} = '0;
      @(negedge clk);
      do_reset();
      sc_bounds();
      sc_index();
      sc_canon();
      sc_surface();
      sc_stall();
      do_reset();
      sc_tiles();
      summarize();
   end
   // Watchdog well past the few dozen cycles the scenarios need
   initial begin
      #200000;
      err_count++;
      summarize();
   end
endmodule
`default_nettype wire
